// *** uep_pkg.sv ***
package uep_pkg;
    localparam int EP_NUM = 4;
    localparam int EP_W = 2;
    localparam int LEN_W = 11;
    localparam int CFG_W = 5;
    localparam int EV_W = 3;
    localparam int CTRL_W = 4;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_TOG = 8'h0C;
    localparam logic [7:0] A_CFG0 = 8'h10;
    localparam logic [7:0] A_CFGN = 8'h20;
    // Control fields
    localparam int C_NAKO = 0;
    localparam int C_NAKI = 1;
    localparam int C_QUIRK = 2;
    localparam int C_GUARD = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    // Event fields
    localparam int E_NAKO = 0;
    localparam int E_NAKI = 1;
    localparam int E_OVER = 2;
    // Endpoint entry fields
    localparam int F_ACT = 0;
    localparam int F_RELOAD = 1;
    localparam int F_RATE = 2;
    localparam int F_KIND = 3;
    localparam int F_CTL = 4;
    localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
    // Maximum packet sizes
    localparam logic [LEN_W-1:0] MPS_CTL = 11'h040;
    localparam logic [LEN_W-1:0] MPS_INT = 11'h400;
    localparam logic [LEN_W-1:0] MPS_BLK = 11'h200;
    localparam logic [LEN_W-1:0] MPS_ISO = 11'h400;
    localparam logic [3:0] LEN_HAZ = 4'h4;
    localparam logic [1:0] R_OKAY = 2'h0;
    localparam logic [1:0] R_SLVERR = 2'h2;
    typedef enum logic [1:0] {UEP_CTL, UEP_BLK, UEP_INT, UEP_ISO} uep_type_t;
endpackage

// *** uep_ep_if.sv ***
`timescale 1ns/1ps
interface uep_ep_if;
    logic active;
    logic reload;
    logic rate;
    logic kind;
    logic quirk;
    logic ack;
    logic tok_hit;
    logic toggle;
    logic arm;
    modport ctl (output active, reload, rate, kind, quirk, ack, tok_hit, input toggle, arm);
    modport slot (input active, reload, rate, kind, quirk, ack, tok_hit, output toggle, arm);
endinterface // uep_ep_if

// *** uep_ep_slot.sv ***
`timescale 1ns/1ps
module uep_ep_slot
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Endpoint state
    uep_ep_if.slot   ep
);
    logic toggle_q;
    logic arm_q;

    assign ep.toggle = toggle_q;
    assign ep.arm = arm_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            toggle_q <= 1'b0;
        else if (ep.reload)
            toggle_q <= (ep.quirk && ep.kind && ep.rate) ? 1'b1 : ep.rate; // RL3 RL4 RL6
        else if (ep.ack && !(ep.kind && !ep.rate))
            toggle_q <= ~toggle_q; // RL14
    end

    // Armed while parked, spent on the first token once live again
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            arm_q <= 1'b0;
        else if (ep.reload && !ep.active)
            arm_q <= 1'b1; // RL9
        else if (ep.tok_hit && ep.active && !ep.reload)
            arm_q <= 1'b0; // RL8
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RELOAD_VAL: assert property (ep.reload && !ep.quirk |=> toggle_q == $past(ep.rate)) // RL3
        else $error("reload did not load rate bit");
    AST_QUIRK_DATA1: assert property (ep.reload && ep.quirk && ep.kind && ep.rate |=> toggle_q) // RL4
        else $error("interrupt reload not DATA1");
    AST_FLIP: assert property (ep.ack && !ep.reload && !(ep.kind && !ep.rate)
        |=> toggle_q != $past(toggle_q)) // RL14
        else $error("toggle did not alternate");
    AST_ISO_HOLD: assert property (ep.ack && !ep.reload && ep.kind && !ep.rate |=> $stable(toggle_q)) // RL2
        else $error("isochronous toggle moved");
endmodule // uep_ep_slot

// *** uep_fbyte.sv ***
`timescale 1ns/1ps
module uep_fbyte
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Events
    input wire logic       quirk,
    input wire logic       out_done,
    input wire logic       out_len4,
    input wire logic       in_nak,
    output logic           hazard,
    // Transmit bytes
    input wire logic       tx_valid,
    input wire logic       tx_first,
    input wire logic [7:0] tx_data,
    output logic           txo_valid,
    output logic [7:0]     txo_data
);
    logic hazard_q;

    assign hazard = hazard_q;

    // Shared by all endpoints: an accepted OUT of length 4+16N arms it, a NAKed IN or a first IN byte spends it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hazard_q <= 1'b0;
        else if (out_done)
            hazard_q <= out_len4; // RL12
        else if (in_nak || (tx_valid && tx_first))
            hazard_q <= 1'b0; // RL13
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            txo_valid <= 1'b0;
            txo_data <= 8'h00;
        end
        else
        begin
            txo_valid <= tx_valid;
            txo_data <= (tx_valid && tx_first && quirk && hazard_q) ? 8'h00 : tx_data; // RL11
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_ZERO_BYTE: assert property (tx_valid && tx_first && quirk && hazard_q |=> txo_data == 8'h00) // RL11
        else $error("affected first byte not zeroed");
    AST_CLEAN_BYTE: assert property (tx_valid && !quirk |=> txo_data == $past(tx_data)) // RL11
        else $error("first byte altered");
    AST_NAK_CURES: assert property (in_nak && !out_done |=> !hazard_q) // RL13
        else $error("NAKed IN did not clear hazard");
endmodule // uep_fbyte

// *** uep_top.sv ***
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - Kind flag of an entry picks generic or periodic endpoint.
// RL2 - Periodic endpoint: rate bit picks interrupt (1) or isochronous (0).
// RL3 - Reload bit set loads the endpoint toggle from the rate bit.
// RL4 - Quirk mode: interrupt endpoint with reload goes to DATA1.
// RL5 - Software enables NAK interrupts for OUT and IN before the reset dance.
// RL6 - Inactive, reload, rate 0, kind 0: NAK tokens and clear toggle.
// RL7 - Endpoint toggles readable; software polls until zero after NAK interrupts.
// RL8 - Active, no reload, rate 1, kind 1: normal interrupt endpoint service.
// RL9 - After the NAK reset the first token is answered with NAK.
// RL10 - Max packet: control 64, interrupt 1024, bulk 512, isochronous 1024.
// RL11 - First IN byte sent unaltered; quirk zeroes it after 4+16N OUT.
// RL12 - Corruption window spans all endpoints and all endpoint types.
// RL13 - A NAKed IN between OUT and IN clears the window; guard NAKs one.
// RL14 - Non-isochronous toggle alternates after every acknowledged transaction; with the reload bit set it stays at the rate bit.
module uep_top
    import uep_pkg::*;
(
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // AXI4-Lite slave
    input wire logic [7:0]       s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    output logic                 s_axi_awready,
    input wire logic [31:0]      s_axi_wdata,
    input wire logic [3:0]       s_axi_wstrb,
    input wire logic             s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [7:0]       s_axi_araddr,
    input wire logic             s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input wire logic             s_axi_rready,
    // Token from packet engine
    input wire logic             tok_valid,
    input wire logic [EP_W-1:0]  tok_ep,
    input wire logic             tok_in,
    input wire logic [LEN_W-1:0] tok_len,
    // Transaction acknowledged
    input wire logic             ack_valid,
    input wire logic [EP_W-1:0]  ack_ep,
    // Handshake answer
    output logic                 hs_valid,
    output logic                 hs_nak,
    output logic                 hs_data1,
    // Transmit bytes
    input wire logic             tx_valid,
    input wire logic             tx_first,
    input wire logic [7:0]       tx_data,
    output logic                 txo_valid,
    output logic [7:0]           txo_data,
    // Interrupt
    output logic                 irq
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [EV_W-1:0]   stat_q;
    logic [EV_W-1:0]   stat_d;
    logic [EV_W-1:0]   mask_q;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   clr;
    logic [CFG_W-1:0]  cfg_q [EP_NUM];
    logic [EP_NUM-1:0] tog;
    logic [EP_NUM-1:0] arm;
    logic [CFG_W-1:0]  cfg_t;
    uep_type_t         ty;
    logic [LEN_W-1:0]  mps;
    logic              over;
    logic              nak;
    logic              hazard;
    logic [7:0]        aw_q;
    logic [31:0]       wd_q;
    logic [3:0]        ws_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic              wr_en;
    logic              wr_ok;
    logic [EP_W-1:0]   wr_idx;
    logic [EP_W-1:0]   rd_idx;
    logic [31:0]       rd_d;
    logic              rd_ok;
    logic [7:0]        wr_off;
    logic [7:0]        rd_off;

    uep_ep_if epi [EP_NUM] ();

    ////////////////////////////////////////////////////////////
    // Endpoint slots

    for (genvar i = 0; i < EP_NUM; i++)
    begin : g_ep
        assign epi[i].active = cfg_q[i][F_ACT];
        assign epi[i].reload = cfg_q[i][F_RELOAD];
        assign epi[i].rate = cfg_q[i][F_RATE];
        assign epi[i].kind = cfg_q[i][F_KIND];
        assign epi[i].quirk = ctrl_q[C_QUIRK];
        assign epi[i].ack = ack_valid && (ack_ep == EP_W'(i));
        assign epi[i].tok_hit = tok_valid && (tok_ep == EP_W'(i));
        assign tog[i] = epi[i].toggle;
        assign arm[i] = epi[i].arm;

        uep_ep_slot u_slot
        (
            .aclk    (aclk),
            .aresetn (aresetn),
            .ep      (epi[i])
        );
    end

    ////////////////////////////////////////////////////////////
    // Token answer

    always_comb
    begin
        cfg_t = cfg_q[tok_ep];
        if (cfg_t[F_KIND])
            ty = cfg_t[F_RATE] ? UEP_INT : UEP_ISO; // RL1 RL2
        else
            ty = cfg_t[F_CTL] ? UEP_CTL : UEP_BLK; // RL1
        case (ty)
            UEP_CTL: mps = MPS_CTL; // RL10
            UEP_INT: mps = MPS_INT; // RL10
            UEP_BLK: mps = MPS_BLK; // RL10
            default: mps = MPS_ISO; // RL10
        endcase
        over = !tok_in && (tok_len > mps); // RL10
        // Oversize OUT is refused rather than truncated
        nak = !cfg_t[F_ACT] || arm[tok_ep] || over // RL6 RL9
            || (tok_in && hazard && ctrl_q[C_GUARD]); // RL13
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hs_valid <= 1'b0;
            hs_nak <= 1'b0;
            hs_data1 <= 1'b0;
        end
        else
        begin
            hs_valid <= tok_valid;
            hs_nak <= tok_valid && nak; // RL8
            hs_data1 <= tog[tok_ep];
        end
    end

    uep_fbyte u_fbyte
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .quirk     (ctrl_q[C_QUIRK]),
        .out_done  (tok_valid && !tok_in && !nak),
        .out_len4  (tok_len[3:0] == LEN_HAZ),
        .in_nak    (tok_valid && tok_in && nak),
        .hazard    (hazard),
        .tx_valid  (tx_valid),
        .tx_first  (tx_first),
        .tx_data   (tx_data),
        .txo_valid (txo_valid),
        .txo_data  (txo_data)
    );

    ////////////////////////////////////////////////////////////
    // Events and interrupt

    always_comb
    begin
        ev = '0;
        ev[E_NAKO] = tok_valid && nak && !tok_in && ctrl_q[C_NAKO]; // RL5
        ev[E_NAKI] = tok_valid && nak && tok_in && ctrl_q[C_NAKI]; // RL5
        ev[E_OVER] = tok_valid && over;
        clr = (wr_en && aw_q == A_STAT && ws_q[0]) ? wd_q[EV_W-1:0] : '0;
        // Set beats clear in the same cycle
        stat_d = (stat_q & ~clr) | ev;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stat_q <= '0;
        else
            stat_q <= stat_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(stat_d & ((wr_en && aw_q == A_MASK && ws_q[0]) ? wd_q[EV_W-1:0] : mask_q));
    end

    ////////////////////////////////////////////////////////////
    // AXI4-Lite write

    assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_off = aw_q - A_CFG0;
    assign wr_idx = wr_off[EP_W+1:2];

    always_comb
    begin
        if (aw_q == A_CTRL || aw_q == A_STAT || aw_q == A_MASK || aw_q == A_TOG)
            wr_ok = 1'b1;
        else if (aw_q >= A_CFG0 && aw_q < A_CFGN && aw_q[1:0] == 2'h0)
            wr_ok = 1'b1;
        else
            wr_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_q <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_q <= s_axi_awaddr;
        end
        else
        begin
            if (wr_en)
                aw_have_q <= 1'b0;
            s_axi_awready <= !aw_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            s_axi_wready <= 1'b0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
        end
        else
        begin
            if (wr_en)
                w_have_q <= 1'b0;
            s_axi_wready <= !w_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= R_OKAY;
        end
        else if (wr_en)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? R_OKAY : R_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // All fields live in byte lane 0
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= CTRL_RST;
        else if (wr_en && aw_q == A_CTRL && ws_q[0])
            ctrl_q <= wd_q[CTRL_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mask_q <= '0;
        else if (wr_en && aw_q == A_MASK && ws_q[0])
            mask_q <= wd_q[EV_W-1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int k = 0; k < EP_NUM; k++)
                cfg_q[k] <= CFG_RST;
        end
        else if (wr_en && wr_ok && aw_q >= A_CFG0 && ws_q[0])
            cfg_q[wr_idx] <= wd_q[CFG_W-1:0];
    end

    ////////////////////////////////////////////////////////////
    // AXI4-Lite read

    assign rd_off = s_axi_araddr - A_CFG0;
    assign rd_idx = rd_off[EP_W+1:2];

    always_comb
    begin
        rd_d = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == A_CTRL)
            rd_d[CTRL_W-1:0] = ctrl_q;
        else if (s_axi_araddr == A_STAT)
            rd_d[EV_W-1:0] = stat_q;
        else if (s_axi_araddr == A_MASK)
            rd_d[EV_W-1:0] = mask_q;
        else if (s_axi_araddr == A_TOG)
            rd_d[EP_NUM-1:0] = tog; // RL7
        else if (s_axi_araddr >= A_CFG0 && s_axi_araddr < A_CFGN && s_axi_araddr[1:0] == 2'h0)
            rd_d[CFG_W-1:0] = cfg_q[rd_idx];
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_axi_arready <= 1'b0;
        else
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= R_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? R_OKAY : R_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_INACTIVE_NAK: assert property (tok_valid && !cfg_t[F_ACT] |=> hs_valid && hs_nak) // RL6
        else $error("inactive endpoint not NAKed");
    AST_FIRST_NAK: assert property (tok_valid && arm[tok_ep] |=> hs_nak) // RL9
        else $error("first token after reset not NAKed");
    AST_LIVE_ACK: assert property (tok_valid && !nak && cfg_t[F_ACT] |=> hs_valid && !hs_nak) // RL8
        else $error("live endpoint NAKed");
    AST_TOG_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_TOG
        |=> s_axi_rvalid && s_axi_rdata[EP_NUM-1:0] == $past(tog)) // RL7
        else $error("toggle register mismatch");
    AST_GUARD_NAK: assert property (tok_valid && tok_in && hazard && ctrl_q[C_GUARD] |=> hs_nak) // RL13
        else $error("guard did not NAK IN");
    AST_OVERSIZE: assert property (tok_valid && !tok_in && tok_len > mps |=> stat_q[E_OVER] && hs_nak) // RL10
        else $error("oversize OUT not flagged");
    AST_NAK_IRQ_GATE: assert property (tok_valid && !tok_in && nak && !ctrl_q[C_NAKO]
        && !stat_q[E_NAKO] |=> !stat_q[E_NAKO]) // RL5
        else $error("NAK event while disabled");
    AST_IRQ_LEVEL: assert property (##1 (stat_q & mask_q) != '0 |-> irq)
        else $error("irq low with pending event");

    COV_RESET_DANCE: cover property (tok_valid && arm[tok_ep] ##[1:50] tok_valid && !nak);
    COV_HAZARD_GUARD: cover property (hazard && tok_valid && tok_in && nak);
    COV_W1C: cover property (wr_en && aw_q == A_STAT ##1 stat_q == '0);
endmodule // uep_top

// *** uep_host_model.sv ***
`timescale 1ns/1ps
module uep_host_model
    import uep_pkg::*;
(
    // Clock
    input wire logic             aclk,
    // Tokens and acknowledges
    output logic                 tok_valid,
    output logic [EP_W-1:0]      tok_ep,
    output logic                 tok_in,
    output logic [LEN_W-1:0]     tok_len,
    output logic                 ack_valid,
    output logic [EP_W-1:0]      ack_ep,
    // Handshake seen
    input wire logic             hs_valid,
    input wire logic             hs_nak,
    input wire logic             hs_data1,
    // IN bytes
    output logic                 tx_valid,
    output logic                 tx_first,
    output logic [7:0]           tx_data,
    input wire logic             txo_valid,
    input wire logic [7:0]       txo_data
);
    initial
    begin
        {tok_valid, tok_ep, tok_in, tok_len, ack_valid, ack_ep, tx_valid, tx_first, tx_data} = '0;
    end
    ////////////////////////////////////////
    // Idle lines show inverted junk, never the stale value
    task automatic token(input logic [EP_W-1:0] e, input logic i, input logic [LEN_W-1:0] n,
                         output logic v, output logic k, output logic d);
        @(posedge aclk);
        tok_valid <= 1'b1;
        tok_ep    <= e;
        tok_in    <= i;
        tok_len   <= n;
        @(posedge aclk);
        tok_valid <= 1'b0;
        tok_ep    <= ~e;
        tok_in    <= ~i;
        tok_len   <= ~n;
        #1;
        v = hs_valid;
        k = hs_nak;
        d = hs_data1;
    endtask
    task automatic ack(input logic [EP_W-1:0] e);
        @(posedge aclk);
        ack_valid <= 1'b1;
        ack_ep    <= e;
        @(posedge aclk);
        ack_valid <= 1'b0;
        ack_ep    <= ~e;
    endtask
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, output logic [7:0] o);
        @(posedge aclk);
        tx_valid <= 1'b1;
        tx_first <= 1'b1;
        tx_data  <= b0;
        @(posedge aclk);
        tx_first <= 1'b0;
        tx_data  <= b1;
        #1;
        o = txo_valid ? txo_data : 8'hXX;
        @(posedge aclk);
        tx_valid <= 1'b0;
        tx_data  <= ~b1;
    endtask
endmodule // uep_host_model

// *** usb_hs_device_endpoint_ctrl_bench.sv ***
`timescale 1ns/1ps
module usb_hs_device_endpoint_ctrl_bench
    import uep_pkg::*;
;
    typedef struct packed {logic [4:0] cfg; logic [10:0] len; logic nak; logic d1;} uep_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, txo_data, o;
    logic [31:0] s_axi_wdata, s_axi_rdata, w;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, ack_ep, tok_ep;
    logic tok_valid, tok_in, ack_valid, hs_valid, hs_nak, hs_data1, tx_valid, tx_first, txo_valid, irq;
    logic [10:0] tok_len;
    logic [7:0] tx_data;
    logic v, k, d;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    uep_row_t rows [12] = '{'{5'h11, 11'h040, 1'b0, 1'b0}, '{5'h11, 11'h041, 1'b1, 1'b0},
        '{5'h01, 11'h200, 1'b0, 1'b0}, '{5'h01, 11'h201, 1'b1, 1'b0}, '{5'h0D, 11'h400, 1'b0, 1'b0},
        '{5'h0D, 11'h401, 1'b1, 1'b0}, '{5'h09, 11'h400, 1'b0, 1'b0}, '{5'h09, 11'h401, 1'b1, 1'b0},
        '{5'h07, 11'h008, 1'b0, 1'b1}, '{5'h0F, 11'h008, 1'b0, 1'b1}, '{5'h03, 11'h008, 1'b0, 1'b0},
        '{5'h00, 11'h008, 1'b1, 1'b0}};
    uep_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in), .tok_len(tok_len), .ack_valid(ack_valid),
        .ack_ep(ack_ep), .hs_valid(hs_valid), .hs_nak(hs_nak), .hs_data1(hs_data1), .tx_valid(tx_valid),
        .tx_first(tx_first), .tx_data(tx_data), .txo_valid(txo_valid), .txo_data(txo_data), .irq(irq));
    uep_host_model host (.aclk(aclk), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in), .tok_len(tok_len),
        .ack_valid(ack_valid), .ack_ep(ack_ep), .hs_valid(hs_valid), .hs_nak(hs_nak), .hs_data1(hs_data1),
        .tx_valid(tx_valid), .tx_first(tx_first), .tx_data(tx_data), .txo_valid(txo_valid), .txo_data(txo_data));
    ////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    ////////////////////////////////////////
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dw);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dw, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1)
        begin
            if (s_axi_awready === 1'b1)
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready === 1'b1)
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~dw};
            @(posedge aclk);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        {w, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic fb_case(input logic [3:0] c, input logic [10:0] n, input logic nk, input logic [7:0] e);
        axi_wr(A_CTRL, {28'h0, c});
        host.token(2'h2, 1'b0, n, v, k, d);
        if (nk)
            host.token(2'h0, 1'b1, 11'h000, v, k, d);
        if (c[C_GUARD])
        begin
            host.token(2'h3, 1'b1, 11'h000, v, k, d);
            chk_bit(k, 1'b1, "guard nak");
        end
        host.token(2'h3, 1'b1, 11'h000, v, k, d);
        chk_bit(k, 1'b0, "in accepted");
        host.send(8'hA5, 8'h3C, o);
        chk_byte(o, e, "first byte");
    endtask
    ////////////////////////////////////////
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(A_CTRL);
        chk_word(w, 32'h0, "ctrl reset");
        axi_rd(A_TOG);
        chk_word(w, 32'h0, "toggle reset");
        axi_rd(8'h40);
        chk_word({w[29:0], r}, {30'h0, R_SLVERR}, "unmapped read");
        axi_wr(8'h44, 32'h1);
        chk_word({30'h0, r}, {30'h0, R_SLVERR}, "unmapped write");
        $display("test reset done");
        foreach (rows[i])
        begin
            axi_wr(A_CFG0, {27'h0, rows[i].cfg});
            host.token(2'h0, 1'b0, rows[i].len, v, k, d);
            chk_bit(v, 1'b1, "hs valid");
            chk_bit(k, rows[i].nak, "hs nak");
            chk_bit(d, rows[i].d1, "hs toggle");
        end
        axi_rd(A_STAT);
        chk_word(w, 32'h4, "oversize flag");
        axi_wr(A_STAT, 32'h7);
        $display("test table done");
        axi_wr(A_CFG0 + 8'h04, 32'h1);
        axi_wr(A_CFG0 + 8'h08, 32'h9);
        for (int i = 0; i < 2; i++)
        begin
            host.ack(2'h1);
            host.ack(2'h2);
            host.token(2'h1, 1'b0, 11'h008, v, k, d);
            chk_bit(d, i == 0, "bulk toggle");
            host.token(2'h2, 1'b0, 11'h008, v, k, d);
            chk_bit(d, 1'b0, "iso toggle");
        end
        $display("test toggle done");
        axi_wr(A_CTRL, 32'h3);
        axi_wr(A_MASK, 32'h3);
        axi_wr(A_CFG0 + 8'h04, 32'hF);
        host.token(2'h1, 1'b1, 11'h000, v, k, d);
        chk_bit(d, 1'b1, "int reload");
        axi_wr(A_CFG0 + 8'h04, 32'h2);
        host.token(2'h1, 1'b1, 11'h000, v, k, d);
        chk_bit(k, 1'b1, "dance nak");
        @(posedge aclk);
        #1 chk_bit(irq, 1'b1, "nak irq");
        axi_rd(A_TOG);
        chk_word(w, 32'h0, "toggle cleared");
        axi_wr(A_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        #1 chk_bit(irq, 1'b0, "irq masked");
        axi_wr(A_MASK, 32'h3);
        axi_wr(A_STAT, 32'h3);
        repeat (2) @(posedge aclk);
        #1 chk_bit(irq, 1'b0, "irq cleared");
        axi_wr(A_CFG0 + 8'h04, 32'hD);
        host.token(2'h1, 1'b1, 11'h000, v, k, d);
        chk_bit(k, 1'b1, "first token nak");
        host.token(2'h1, 1'b1, 11'h000, v, k, d);
        chk_bit(k, 1'b0, "service resumed");
        chk_bit(d, 1'b0, "resumed data0");
        axi_wr(A_STAT, 32'h7);
        $display("test nak reset done");
        axi_wr(A_CFG0 + 8'h08, 32'h1);
        axi_wr(A_CFG0 + 8'h0C, 32'h1);
        fb_case(4'h0, 11'h004, 1'b0, 8'hA5);
        fb_case(4'h4, 11'h014, 1'b0, 8'h00);
        fb_case(4'h4, 11'h024, 1'b1, 8'hA5);
        fb_case(4'hC, 11'h004, 1'b0, 8'hA5);
        fb_case(4'h4, 11'h008, 1'b0, 8'hA5);
        $display("test first byte done");
        summarize();
    end
endmodule // usb_hs_device_endpoint_ctrl_bench
